// ==== pwm_ovd_pkg.sv ====
// Purpose: Shared constants for the PWM override and duty register block
// Assumes: AHB-Lite slave with 32-bit data, one word per register
// Notes: Offsets are byte addresses, decoded on haddr[7:0]
package pwm_ovd_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_GEN = 4;
    localparam int DUTY_W = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_OVERRIDE = 8'h00;
    localparam logic [7:0] OFS_DUTY_ONE = 8'h04;
    localparam logic [7:0] OFS_DUTY_TWO = 8'h08;
    localparam logic [7:0] OFS_DUTY_THREE = 8'h0C;
    localparam logic [7:0] OFS_DUTY_FOUR = 8'h10;
    localparam logic [7:0] OFS_FAULT_CTRL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] OVERRIDE_RESET = 16'hFF00;
    localparam logic [15:0] DUTY_RESET = 16'h0000;
    localparam logic [23:0] FAULT_CTRL_RESET = 24'h00_0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OVD_SEL_LSB = 8;
    localparam int MAN_LVL_LSB = 0;
    localparam int FB_EN_LSB = 0;
    localparam int FA_EN_LSB = 4;
    localparam int FB_VAL_LSB = 8;
    localparam int FA_VAL_LSB = 16;
    localparam int STAT_FA_BIT = 8;
    localparam int STAT_FB_BIT = 9;

    // Writable bit masks
    localparam logic [31:0] MASK_HALF = 32'h0000_FFFF;
    localparam logic [31:0] MASK_FAULT = 32'h00FF_FFFF;
    localparam logic [31:0] MASK_NONE = 32'h0000_0000;

endpackage

// ==== pwm_pin_select.sv ====
// Purpose: One generator: compare, override choice and fault forcing
// Assumes: Time base count comes from logic on the same clock
// Notes: Pins are active high; in generator mode low pin is complement of high
`timescale 1ns/1ps
`default_nettype none
module pwm_pin_select (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [15:0] duty,
    input wire logic [15:0] count,
    input wire logic ovd_high,
    input wire logic ovd_low,
    input wire logic man_high,
    input wire logic man_low,
    input wire logic fault_a_act,
    input wire logic fault_b_act,
    input wire logic fa_val_high,
    input wire logic fa_val_low,
    input wire logic fb_val_high,
    input wire logic fb_val_low,
    output logic pin_high,
    output logic pin_low
);

    // ------------------------------------------------------------
    // Pin selection
    // ------------------------------------------------------------
    wire logic raw_high;
    wire logic raw_low;
    wire logic sel_high;
    wire logic sel_low;
    wire logic next_high;
    wire logic next_low;

    // No dead time here; the gate driver stage must supply it
    assign raw_high = duty > count;
    assign raw_low = ~raw_high;
    assign sel_high = ovd_high ? raw_high : man_high;
    assign sel_low = ovd_low ? raw_low : man_low;
    // Fault A checked first so it outranks fault B
    assign next_high = fault_a_act ? fa_val_high : (fault_b_act ? fb_val_high : sel_high);
    assign next_low = fault_a_act ? fa_val_low : (fault_b_act ? fb_val_low : sel_low);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_high <= 1'b0;
            pin_low <= 1'b0;
        end else begin
            pin_high <= next_high;
            pin_low <= next_low;
        end
    end

endmodule
`default_nettype wire

// ==== pwm_override_top.sv ====
// Purpose: PWM pin override and duty registers behind an AHB-Lite slave
// Assumes: Fault pins are asynchronous and active high
// Notes: Zero wait states; unmapped reads return zero
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pwm_override_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] time_base_count,
    input wire logic fault_a_in,
    input wire logic fault_b_in,
    output logic [3:0] generator_high_output,
    output logic [3:0] generator_low_output
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] write_mask(input logic [7:0] a);
        if (a == pwm_ovd_pkg::OFS_FAULT_CTRL) begin
            return pwm_ovd_pkg::MASK_FAULT;
        end else if (a == pwm_ovd_pkg::OFS_OVERRIDE || a == pwm_ovd_pkg::OFS_DUTY_ONE
                || a == pwm_ovd_pkg::OFS_DUTY_TWO || a == pwm_ovd_pkg::OFS_DUTY_THREE
                || a == pwm_ovd_pkg::OFS_DUTY_FOUR) begin
            return pwm_ovd_pkg::MASK_HALF;
        end else begin
            return pwm_ovd_pkg::MASK_NONE;
        end
    endfunction

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [15:0] pwm_pin_override_control;
    logic [15:0] duty [4];
    logic [23:0] fault_ctrl;
    logic fa_meta;
    logic fa_sync;
    logic fb_meta;
    logic fb_sync;
    wire logic take;
    wire logic take_rd;
    wire logic [7:0] rd_addr;
    wire logic fwd;
    wire logic [31:0] stored;
    wire logic [31:0] status;
    wire logic [31:0] next_rdata;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && htrans[1] && hready;
    assign take_rd = take && !hwrite;
    assign rd_addr = haddr[7:0];
    assign status = {22'h00_0000, fb_sync, fa_sync,
        generator_high_output[3], generator_low_output[3],
        generator_high_output[2], generator_low_output[2],
        generator_high_output[1], generator_low_output[1],
        generator_high_output[0], generator_low_output[0]};
    assign stored = (rd_addr == pwm_ovd_pkg::OFS_OVERRIDE) ? {16'h0000, pwm_pin_override_control}
        : (rd_addr == pwm_ovd_pkg::OFS_DUTY_ONE) ? {16'h0000, duty[0]}
        : (rd_addr == pwm_ovd_pkg::OFS_DUTY_TWO) ? {16'h0000, duty[1]}
        : (rd_addr == pwm_ovd_pkg::OFS_DUTY_THREE) ? {16'h0000, duty[2]}
        : (rd_addr == pwm_ovd_pkg::OFS_DUTY_FOUR) ? {16'h0000, duty[3]}
        : (rd_addr == pwm_ovd_pkg::OFS_FAULT_CTRL) ? {8'h00, fault_ctrl}
        : (rd_addr == pwm_ovd_pkg::OFS_STATUS) ? status : 32'h0000_0000;
    // A read right behind a write sees the new value, not the stale one
    assign fwd = wr_pend && (wr_addr == rd_addr) && (write_mask(rd_addr) != 32'h0000_0000);
    assign next_rdata = fwd ? (hwdata & write_mask(rd_addr)) : stored;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= take && hwrite;
            if (take) begin
                wr_addr <= haddr[7:0];
            end
            if (take_rd) begin
                hrdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_pin_override_control <= pwm_ovd_pkg::OVERRIDE_RESET;
            fault_ctrl <= pwm_ovd_pkg::FAULT_CTRL_RESET;
        end else if (wr_pend) begin
            if (wr_addr == pwm_ovd_pkg::OFS_OVERRIDE) begin
                pwm_pin_override_control <= hwdata[15:0];
            end
            if (wr_addr == pwm_ovd_pkg::OFS_FAULT_CTRL) begin
                fault_ctrl <= hwdata[23:0];
            end
        end
    end

    generate
        for (genvar g = 0; g < pwm_ovd_pkg::NUM_GEN; g++) begin : g_duty
            localparam logic [7:0] OFS = pwm_ovd_pkg::OFS_DUTY_ONE + 8'(4 * g);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    duty[g] <= pwm_ovd_pkg::DUTY_RESET;
                end else if (wr_pend && wr_addr == OFS) begin
                    duty[g] <= hwdata[15:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Fault input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fa_meta <= 1'b0;
            fa_sync <= 1'b0;
            fb_meta <= 1'b0;
            fb_sync <= 1'b0;
        end else begin
            fa_meta <= fault_a_in;
            fa_sync <= fa_meta;
            fb_meta <= fault_b_in;
            fb_sync <= fb_meta;
        end
    end

    // ------------------------------------------------------------
    // Generators
    // ------------------------------------------------------------
    wire logic [3:0] fa_act;
    wire logic [3:0] fb_act;
    wire logic [7:0] ovd_sel;
    wire logic [7:0] man_lvl;
    wire logic [7:0] fa_val;
    wire logic [7:0] fb_val;

    assign fa_act = fault_ctrl[pwm_ovd_pkg::FA_EN_LSB +: 4] & {4{fa_sync}};
    assign fb_act = fault_ctrl[pwm_ovd_pkg::FB_EN_LSB +: 4] & {4{fb_sync}};
    assign ovd_sel = pwm_pin_override_control[pwm_ovd_pkg::OVD_SEL_LSB +: 8];
    assign man_lvl = pwm_pin_override_control[pwm_ovd_pkg::MAN_LVL_LSB +: 8];
    assign fa_val = fault_ctrl[pwm_ovd_pkg::FA_VAL_LSB +: 8];
    assign fb_val = fault_ctrl[pwm_ovd_pkg::FB_VAL_LSB +: 8];

    generate
        for (genvar g = 0; g < pwm_ovd_pkg::NUM_GEN; g++) begin : g_gen
            // Bit 2g+1 is the high pin, bit 2g the low pin
            pwm_pin_select u_sel (
                .hclk(hclk),
                .hresetn(hresetn),
                .duty(duty[g]),
                .count(time_base_count),
                .ovd_high(ovd_sel[2 * g + 1]),
                .ovd_low(ovd_sel[2 * g]),
                .man_high(man_lvl[2 * g + 1]),
                .man_low(man_lvl[2 * g]),
                .fault_a_act(fa_act[g]),
                .fault_b_act(fb_act[g]),
                .fa_val_high(fa_val[2 * g + 1]),
                .fa_val_low(fa_val[2 * g]),
                .fb_val_high(fb_val[2 * g + 1]),
                .fb_val_low(fb_val[2 * g]),
                .pin_high(generator_high_output[g]),
                .pin_low(generator_low_output[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence both_faults_s;
        fa_act[0] && fb_act[0];
    endsequence

    sequence quiet_pair3_s;
        !fa_act[3] && !fb_act[3];
    endsequence

    fault_a_prio_a: assert property (both_faults_s |=> generator_high_output[0] == $past(fa_val[1])
        && generator_low_output[0] == $past(fa_val[0]))
        else $error("fault A did not outrank fault B");
    gen_waveform_a: assert property (!fa_act[0] && !fb_act[0] && ovd_sel[1]
        |=> generator_high_output[0] == ($past(duty[0]) > $past(time_base_count)))
        else $error("selected pin did not follow generator");
    manual_drive_a: assert property (!fa_act[1] && !fb_act[1] && !ovd_sel[2]
        |=> generator_low_output[1] == $past(man_lvl[2]))
        else $error("manual pin did not follow manual bit");
    manual_level_a: assert property (!fa_act[2] && !fb_act[2] && !ovd_sel[5] && man_lvl[5]
        |=> generator_high_output[2])
        else $error("manual one did not drive active");
    layout_top_a: assert property (quiet_pair3_s ##0 !pwm_pin_override_control[15]
        |=> generator_high_output[3] == $past(pwm_pin_override_control[7]))
        else $error("generator four high pin mapped wrongly");
    duty_store_a: assert property (wr_pend && wr_addr == pwm_ovd_pkg::OFS_DUTY_THREE
        |=> duty[2] == $past(hwdata[15:0]) ##1 ($stable(duty[2]) || $past(wr_pend)))
        else $error("duty register did not store write");
    zero_duty_a: assert property (quiet_pair3_s ##0 duty[3] == 16'h0000 && ovd_sel[6]
        |=> !generator_low_output[3] == 1'b0)
        else $error("zero duty did not hold low pin active");
    fault_b_force_a: assert property (fb_act[1] && !fa_act[1]
        |=> generator_high_output[1] == $past(fb_val[3]) && generator_low_output[1] == $past(fb_val[2]))
        else $error("fault B did not force pair");
    read_back_a: assert property (take_rd && !wr_pend && rd_addr == pwm_ovd_pkg::OFS_DUTY_TWO
        |=> hrdata == {16'h0000, $past(duty[1])})
        else $error("read data mismatch");

endmodule
`default_nettype wire

// ==== gate_drive_model.sv ====
// Purpose: Power stage gate driver seen from the PWM pins
// Assumes: Pins active high, sampled on the bus clock
// Notes: Flags any cycle where both pins of a pair are on
`timescale 1ns/1ps
`default_nettype none
module gate_drive_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [3:0] pin_high,
    input wire logic [3:0] pin_low,
    output logic [7:0] gate_state,
    output logic shoot_through
);
    // ------------------------------------------------------------
    // Gate latch
    // ------------------------------------------------------------
    // Sticky, so a one-cycle overlap is never missed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_state <= 8'h00;
            shoot_through <= 1'b0;
        end else begin
            gate_state <= {pin_high, pin_low};
            if ((pin_high & pin_low) != 4'h0) begin
                shoot_through <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb_pwm_override_and_duty_regs.sv ====
// Purpose: Self-checking bench for the override and duty block
// Assumes: Single AHB-Lite slave, hready fed from hreadyout
// Notes: Reference model kept in integers, compared at each result
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_override_and_duty_regs;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fa = 0, fb = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] cnt = 0;
    logic [3:0] ph, pl;
    logic [7:0] gates;
    logic hready, hresp, shoot;
    int failures = 0, checked = 0, seed = 55413, ovd = 32'hFF00, fctl = 0, i, k;
    int duty[4] = '{0, 0, 0, 0};
    logic [31:0] rd;
    always #12.5 hclk = ~hclk;
    pwm_override_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .time_base_count(cnt),
        .fault_a_in(fa), .fault_b_in(fb), .generator_high_output(ph),
        .generator_low_output(pl));
    gate_drive_model far (.hclk(hclk), .hresetn(hresetn), .pin_high(ph), .pin_low(pl),
        .gate_state(gates), .shoot_through(shoot));
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0000_00, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Pins lag by one edge, faults by two more through the synchroniser
    function automatic logic [7:0] exp_pins();
        logic [3:0] h, l;
        logic w;
        for (int g = 0; g < 4; g++) begin
            w = duty[g] > int'(cnt);
            h[g] = ovd[9 + 2 * g] ? w : ovd[1 + 2 * g];
            l[g] = ovd[8 + 2 * g] ? !w : ovd[2 * g];
            if (fa && fctl[4 + g]) begin
                h[g] = fctl[17 + 2 * g];
                l[g] = fctl[16 + 2 * g];
            end else if (fb && fctl[g]) begin
                h[g] = fctl[9 + 2 * g];
                l[g] = fctl[8 + 2 * g];
            end
        end
        return {h, l};
    endfunction
    task automatic pins();
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        chk({24'h0000_00, ph, pl}, {24'h0000_00, exp_pins()});
    endtask
    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        failures++;
        results();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(0, pwm_ovd_pkg::OFS_OVERRIDE, 0);
        chk(rd, 32'h0000_FF00);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
        for (i = 0; i < 4; i++) begin
            xfer(0, pwm_ovd_pkg::OFS_DUTY_ONE + 8'(4 * i), 0);
            chk(rd, 32'h0000_0000);
        end
        pins();
        $display("reset test done");
        for (i = 0; i < 4; i++) begin
            duty[i] = $random(seed) & 32'h0000_FFFF;
            xfer(1, pwm_ovd_pkg::OFS_DUTY_ONE + 8'(4 * i), duty[i] | 32'hA5A5_0000);
            xfer(0, pwm_ovd_pkg::OFS_DUTY_ONE + 8'(4 * i), 0);
            chk(rd, duty[i]);
        end
        xfer(0, 8'h1C, 0);
        chk(rd, 32'h0000_0000);
        $display("duty test done");
        for (k = 0; k < 10; k++) begin
            @(posedge hclk);
            cnt <= (k < 4) ? duty[k] : $random(seed);
            pins();
        end
        // Generator mode drives the low pin as the complement, so no overlap
        chk({31'h0000_0000, shoot}, 32'h0000_0000);
        $display("generator test done");
        for (k = 0; k < 8; k++) begin
            ovd = $random(seed) & ((k < 2) ? 32'h0000_00FF : 32'h0000_FFFF);
            xfer(1, pwm_ovd_pkg::OFS_OVERRIDE, ovd);
            xfer(0, pwm_ovd_pkg::OFS_OVERRIDE, 0);
            chk(rd, ovd);
            pins();
        end
        $display("override test done");
        fctl = ($random(seed) & 32'h00FF_FF00) | 32'h0000_005F;
        xfer(1, pwm_ovd_pkg::OFS_FAULT_CTRL, fctl);
        @(posedge hclk);
        fb <= 1'b1;
        pins();
        @(posedge hclk);
        fa <= 1'b1;
        pins();
        xfer(0, pwm_ovd_pkg::OFS_STATUS, 0);
        chk(rd & 32'h0000_0300, 32'h0000_0300);
        pins();
        @(posedge hclk);
        fa <= 1'b0;
        fb <= 1'b0;
        pins();
        chk({24'h0000_00, gates}, {24'h0000_00, exp_pins()});
        $display("fault test done");
        results();
    end
endmodule
`default_nettype wire
